// [src/slc_pkg.sv]
// Package: register map, reset values and carriers of the lane config bank
package slc_pkg;
   // Register indices; the byte address is four times the index
   localparam logic [11:0] SLC_IDX_CFW = 12'h592;
   localparam logic [11:0] SLC_IDX_CK0 = 12'h5A0;
   localparam logic [11:0] SLC_IDX_CK1 = 12'h5A1;
   localparam logic [11:0] SLC_IDX_CK2 = 12'h5A2;
   localparam logic [11:0] SLC_IDX_CK3 = 12'h5A3;
   localparam logic [11:0] SLC_IDX_PD = 12'h5B0;
   localparam logic [11:0] SLC_IDX_MAP0 = 12'h5B2;
   localparam logic [11:0] SLC_IDX_MAP1 = 12'h5B3;
   localparam logic [11:0] SLC_IDX_MAP2 = 12'h5B5;
   localparam logic [11:0] SLC_IDX_MAP3 = 12'h5B6;
   localparam logic [11:0] SLC_IDX_INV = 12'h5BF;
   // Field layout
   localparam int SLC_CFW_W = 5;
   localparam int SLC_MAP_W = 3;
   localparam int SLC_LANES = 4;
   localparam logic [7:0] SLC_PD_MASK = 8'h55;
   // Reset values
   localparam logic [7:0] SLC_RST_CK0 = 8'hC3;
   localparam logic [7:0] SLC_RST_CK1 = 8'hC4;
   localparam logic [7:0] SLC_RST_CK2 = 8'hC5;
   localparam logic [7:0] SLC_RST_CK3 = 8'hC6;
   localparam logic [7:0] SLC_RST_PD = 8'h00;
   localparam logic [7:0] SLC_RST_INV = 8'h00;
   localparam logic [2:0] SLC_RST_MAP0 = 3'h0;
   localparam logic [2:0] SLC_RST_MAP1 = 3'h1;
   localparam logic [2:0] SLC_RST_MAP2 = 3'h2;
   localparam logic [2:0] SLC_RST_MAP3 = 3'h3;
   localparam logic [2:0] SLC_MAP_MAX = 3'h3;
   // Bus slave states, Gray coded along the path
   typedef enum logic [1:0] {
      SLC_ST_IDLE = 2'b00,
      SLC_ST_DATA = 2'b01,
      SLC_ST_STALL = 2'b11
   } slc_state_t;
   // Per-lane settings handed to each lane path
   typedef struct packed {
      logic pd;
      logic inv;
      logic [2:0] map;
   } slc_lane_cfg_t;
   // Captured address phase
   typedef struct packed {
      logic wr;
      logic [11:0] idx;
      logic mapped;
   } slc_addr_t;
endpackage : slc_pkg

// [src/slc_lane_path.sv]
// One physical lane: logical lane select, polarity and power-down
`timescale 1ns/100ps
module slc_lane_path #(
   parameter int W = 8
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic clk_en,
   input wire slc_pkg::slc_lane_cfg_t cfg,
   input wire logic [slc_pkg::SLC_LANES-1:0][W-1:0] logical_data,
   output logic [W-1:0] lane_data_r,
   output logic lane_pd_r
);
   import slc_pkg::*;

   logic [W-1:0] lane_nxt;

   // Reserved codes carry nothing rather than alias a real lane
   always_comb begin
      if (cfg.pd || cfg.map > SLC_MAP_MAX) begin
         lane_nxt = '0;
      end else begin
         lane_nxt = logical_data[cfg.map[1:0]] ^ {W{cfg.inv}};
      end
   end

   // Only this lane's settings reach this lane's flops
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lane_data_r <= '0;
         lane_pd_r <= 1'b0;
      end else if (clk_en) begin
         lane_data_r <= lane_nxt;
         lane_pd_r <= cfg.pd;
      end
   end

   property p_lane_inv;
      @(posedge hclk) disable iff (!hresetn)
      (clk_en && !cfg.pd && cfg.map <= SLC_MAP_MAX && cfg.inv)
         |=> (lane_data_r == ~$past(logical_data[cfg.map[1:0]]));
   endproperty
   a_lane_inv: assert property (p_lane_inv)
      else $error("inverted lane data wrong");

   property p_lane_pd;
      @(posedge hclk) disable iff (!hresetn)
      (clk_en && cfg.pd) |=> (lane_data_r == '0 && lane_pd_r);
   endproperty
   a_lane_pd: assert property (p_lane_pd)
      else $error("powered-down lane still carries data");
endmodule : slc_lane_path

// [src/slc_lane_regs.sv]
// Top: lane config and status register bank on AHB-Lite with lane paths
//
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module slc_lane_regs #(
   parameter int W = 8,
   parameter int NPARAM = 13
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic clk_en,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [slc_pkg::SLC_CFW_W-1:0] ctrl_words_per_frame,
   input wire logic [NPARAM-1:0][7:0] link_cfg_octets,
   input wire logic [slc_pkg::SLC_LANES-1:0][W-1:0] logical_lane_data,
   output logic [W-1:0] serial_out_lane_zero,
   output logic [W-1:0] serial_out_lane_one,
   output logic [W-1:0] serial_out_lane_two,
   output logic [W-1:0] serial_out_lane_three,
   output logic [slc_pkg::SLC_LANES-1:0] lane_powered_down
);
   import slc_pkg::*;

   // Sum of the octets shared by every lane, modulo 256
   function automatic logic [7:0] shared_sum(
      input logic [NPARAM-1:0][7:0] oct);
      logic [7:0] s;
      s = 8'h00;
      for (int i = 0; i < NPARAM; i++) begin
         s = s + oct[i];
      end
      return s;
   endfunction : shared_sum

   // Index decode, shared by the address and read paths
   function automatic logic idx_mapped(input logic [11:0] idx);
      case (idx)
         SLC_IDX_CFW, SLC_IDX_CK0, SLC_IDX_CK1, SLC_IDX_CK2,
         SLC_IDX_CK3, SLC_IDX_PD, SLC_IDX_MAP0, SLC_IDX_MAP1,
         SLC_IDX_MAP2, SLC_IDX_MAP3, SLC_IDX_INV: idx_mapped = 1'b1;
         default: idx_mapped = 1'b0;
      endcase
   endfunction : idx_mapped

   slc_state_t state_r;
   slc_state_t state_nxt;
   slc_addr_t ap_r;
   slc_addr_t ap_nxt;
   logic take;
   logic wr_do;
   logic rd_now;
   logic [SLC_CFW_W-1:0] cfw_r;
   logic [7:0] pd_r;
   logic [7:0] inv_r;
   logic [SLC_LANES-1:0][SLC_MAP_W-1:0] map_r;
   logic [SLC_LANES-1:0][7:0] ck_r;
   logic [SLC_LANES-1:0][7:0] ck_nxt;
   logic [7:0] base_sum;
   logic [31:0] rd_val;
   logic [11:0] rd_idx;
   logic first_r;
   slc_lane_cfg_t lane_cfg [SLC_LANES];
   logic [SLC_LANES-1:0][W-1:0] lane_out;

   // Address phase accepted when selected, NONSEQ or SEQ (htrans[1] set) and bus ready
   assign take = hsel && htrans[1] && hready;
   assign ap_nxt = '{wr: hwrite, idx: haddr[13:2],
                     mapped: idx_mapped(haddr[13:2]) && haddr[31:14] == '0};
   // Write lands at the end of its data phase
   assign wr_do = clk_en && state_r == SLC_ST_DATA && ap_r.wr && ap_r.mapped;
   // A read arriving alongside a write data phase stalls one cycle so
   // that it returns the freshly written value
   assign rd_now = take && !hwrite && !(state_r == SLC_ST_DATA && ap_r.wr);

   // Bus sequencing
   always_comb begin
      case (state_r)
         SLC_ST_IDLE: state_nxt = take ? SLC_ST_DATA : SLC_ST_IDLE;
         SLC_ST_DATA: begin
            if (take && !rd_now && !hwrite) begin
               state_nxt = SLC_ST_STALL;
            end else begin
               state_nxt = take ? SLC_ST_DATA : SLC_ST_IDLE;
            end
         end
         SLC_ST_STALL: state_nxt = SLC_ST_DATA;
         default: state_nxt = SLC_ST_IDLE;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r <= SLC_ST_IDLE;
         ap_r <= '0;
      end else if (clk_en) begin
         state_r <= state_nxt;
         if (take) begin
            ap_r <= ap_nxt;
         end
      end
   end

   // Wait state only during the deferred read; response always OKAY
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else if (clk_en) begin
         hreadyout <= state_nxt != SLC_ST_STALL;
         hresp <= 1'b0;
      end
   end

   // Read mux over current register state; unmapped reads return zero
   assign rd_idx = (state_r == SLC_ST_STALL) ? ap_r.idx : haddr[13:2];
   always_comb begin
      rd_val = 32'h0000_0000;
      case (rd_idx)
         SLC_IDX_CFW: rd_val[SLC_CFW_W-1:0] = cfw_r;
         SLC_IDX_CK0: rd_val[7:0] = ck_r[0];
         SLC_IDX_CK1: rd_val[7:0] = ck_r[1];
         SLC_IDX_CK2: rd_val[7:0] = ck_r[2];
         SLC_IDX_CK3: rd_val[7:0] = ck_r[3];
         SLC_IDX_PD: rd_val[7:0] = pd_r & SLC_PD_MASK;
         SLC_IDX_MAP0: rd_val[SLC_MAP_W-1:0] = map_r[0];
         SLC_IDX_MAP1: rd_val[SLC_MAP_W-1:0] = map_r[1];
         SLC_IDX_MAP2: rd_val[SLC_MAP_W-1:0] = map_r[2];
         SLC_IDX_MAP3: rd_val[SLC_MAP_W-1:0] = map_r[3];
         SLC_IDX_INV: rd_val[7:0] = inv_r;
         default: rd_val = 32'h0000_0000;
      endcase
      // A deferred read keeps the decode of its own address phase
      if (state_r == SLC_ST_STALL ? !ap_r.mapped : haddr[31:14] != '0) begin
         rd_val = 32'h0000_0000;
      end
   end

   // Read data is loaded for the data phase and held otherwise
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (clk_en && (rd_now || state_r == SLC_ST_STALL)) begin
         hrdata <= rd_val;
      end
   end

   // Control words per frame mirrors the link setting; not writable
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfw_r <= '0;
      end else if (clk_en) begin
         cfw_r <= ctrl_words_per_frame;
      end
   end

   // Power-down and polarity; only even power-down bits are stored
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pd_r <= SLC_RST_PD;
         inv_r <= SLC_RST_INV;
      end else if (wr_do) begin
         if (ap_r.idx == SLC_IDX_PD) begin
            pd_r <= hwdata[7:0] & SLC_PD_MASK;
         end
         if (ap_r.idx == SLC_IDX_INV) begin
            inv_r <= hwdata[7:0];
         end
      end
   end

   // Lane assignment, identity after reset; each field has its own index
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         map_r[0] <= SLC_RST_MAP0;
         map_r[1] <= SLC_RST_MAP1;
         map_r[2] <= SLC_RST_MAP2;
         map_r[3] <= SLC_RST_MAP3;
      end else if (wr_do) begin
         case (ap_r.idx)
            SLC_IDX_MAP0: map_r[0] <= hwdata[SLC_MAP_W-1:0];
            SLC_IDX_MAP1: map_r[1] <= hwdata[SLC_MAP_W-1:0];
            SLC_IDX_MAP2: map_r[2] <= hwdata[SLC_MAP_W-1:0];
            SLC_IDX_MAP3: map_r[3] <= hwdata[SLC_MAP_W-1:0];
            default: map_r <= map_r;
         endcase
      end
   end

   // Checksum per lane: shared octets plus that lane's logical lane id
   assign base_sum = shared_sum(link_cfg_octets);
   always_comb begin
      for (int n = 0; n < SLC_LANES; n++) begin
         ck_nxt[n] = base_sum + {5'h00, map_r[n]};
      end
   end

   // Reset values stand until the first enabled cycle recomputes them
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ck_r[0] <= SLC_RST_CK0;
         ck_r[1] <= SLC_RST_CK1;
         ck_r[2] <= SLC_RST_CK2;
         ck_r[3] <= SLC_RST_CK3;
      end else if (clk_en) begin
         ck_r <= ck_nxt;
      end
   end

   // One lane path per physical lane
   for (genvar g = 0; g < SLC_LANES; g++) begin : g_lane
      assign lane_cfg[g] = '{pd: pd_r[2*g], inv: inv_r[2*g], map: map_r[g]};
      slc_lane_path #(
         .W(W)
      ) u_path (
         .hclk(hclk),
         .hresetn(hresetn),
         .clk_en(clk_en),
         .cfg(lane_cfg[g]),
         .logical_data(logical_lane_data),
         .lane_data_r(lane_out[g]),
         .lane_pd_r(lane_powered_down[g])
      );

      property p_ck_sum;
         @(posedge hclk) disable iff (!hresetn)
         clk_en |=> ck_r[g] == 8'($past(base_sum) + $past(map_r[g]));
      endproperty
      a_ck_sum: assert property (p_ck_sum)
         else $error("lane checksum not sum mod 256");
   end

   assign serial_out_lane_zero = lane_out[0];
   assign serial_out_lane_one = lane_out[1];
   assign serial_out_lane_two = lane_out[2];
   assign serial_out_lane_three = lane_out[3];

   // Marks the first cycle after reset release for the checks below
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         first_r <= 1'b1;
      end else begin
         first_r <= 1'b0;
      end
   end

   property p_cfw_read;
      @(posedge hclk) disable iff (!hresetn)
      (rd_now && clk_en && haddr == {18'h0, SLC_IDX_CFW, 2'b00})
         |=> (hrdata[31:5] == '0 && hrdata[4:0] == $past(cfw_r));
   endproperty
   a_cfw_read: assert property (p_cfw_read)
      else $error("control word count read wrong");

   property p_ck_reset;
      @(posedge hclk) disable iff (!hresetn)
      first_r |-> ck_r == {SLC_RST_CK3, SLC_RST_CK2, SLC_RST_CK1,
                           SLC_RST_CK0};
   endproperty
   a_ck_reset: assert property (p_ck_reset)
      else $error("checksum reset values wrong");

   property p_pd_odd;
      @(posedge hclk) disable iff (!hresetn)
      (pd_r & ~SLC_PD_MASK) == 8'h00 && lane_powered_down ==
         {pd_r[6], pd_r[4], pd_r[2], pd_r[0]} || $changed(pd_r);
   endproperty
   a_pd_odd: assert property (p_pd_odd)
      else $error("power-down odd bits set or lane flag stale");

   property p_map_write;
      @(posedge hclk) disable iff (!hresetn)
      (wr_do && ap_r.idx == SLC_IDX_MAP2)
         |=> map_r[2] == $past(hwdata[2:0]);
   endproperty
   a_map_write: assert property (p_map_write)
      else $error("lane assignment write lost");

   property p_map_reset;
      @(posedge hclk) disable iff (!hresetn)
      first_r |-> map_r == {SLC_RST_MAP3, SLC_RST_MAP2, SLC_RST_MAP1,
                            SLC_RST_MAP0};
   endproperty
   a_map_reset: assert property (p_map_reset)
      else $error("lane assignment not identity after reset");

   property p_map_isolate;
      @(posedge hclk) disable iff (!hresetn)
      (wr_do && ap_r.idx == SLC_IDX_MAP0) |=> $stable(map_r[3:1]);
   endproperty
   a_map_isolate: assert property (p_map_isolate)
      else $error("lane 0 write disturbed another lane");

   property p_read_ready;
      @(posedge hclk) disable iff (!hresetn)
      (clk_en && state_r == SLC_ST_STALL) |=> hreadyout ##0
         hrdata == $past(rd_val);
   endproperty
   a_read_ready: assert property (p_read_ready)
      else $error("deferred read not completed in one cycle");
endmodule : slc_lane_regs

// [test/slc_rx_model.sv]
// Far-end receiver model: captures every physical lane word each clock
`timescale 1ns/100ps
module slc_rx_model #(
   parameter int W = 8
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [W-1:0] lane0,
   input wire logic [W-1:0] lane1,
   input wire logic [W-1:0] lane2,
   input wire logic [W-1:0] lane3,
   input wire logic [3:0] lane_off,
   output logic [3:0][W-1:0] rx_words_r,
   output logic [3:0] rx_off_r
);
   // One register stage, as a receiver front end adds latency; no alignment
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_words_r <= '0;
         rx_off_r <= 4'h0;
      end else begin
         rx_words_r <= {lane3, lane2, lane1, lane0};
         rx_off_r <= lane_off;
      end
   end
endmodule : slc_rx_model

// [test/tb_slc_lane_regs.sv]
// Testbench: register map, lane routing and checksums of the lane bank
`timescale 1ns/100ps
module tb_slc_lane_regs;
   import slc_pkg::*;
   localparam int W = 8;
   localparam int NP = 13;
   localparam logic [11:0] MAPI [4] = '{SLC_IDX_MAP0, SLC_IDX_MAP1,
      SLC_IDX_MAP2, SLC_IDX_MAP3};
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic clk_en = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic hreadyout;
   logic hresp;
   logic [31:0] hrdata;
   logic [SLC_CFW_W-1:0] cfw_in = 5'h1F;
   logic [NP-1:0][7:0] octets = {{(NP-1){8'h00}}, 8'hC3};
   logic [3:0][W-1:0] ldata = {8'h44, 8'h33, 8'h22, 8'h11};
   logic [W-1:0] so0;
   logic [W-1:0] so1;
   logic [W-1:0] so2;
   logic [W-1:0] so3;
   logic [3:0] lane_pd;
   logic [3:0][W-1:0] rx_words;
   logic [3:0] rx_off;
   logic [2:0] map_e [4] = '{3'h0, 3'h1, 3'h2, 3'h3};
   logic [7:0] pd_e = 8'h00;
   logic [7:0] inv_e = 8'h00;
   int errors = 0;
   int samples_checked = 0;

   // Free-running bus clock
   always #4 hclk = ~hclk;

   slc_lane_regs #(.W(W), .NPARAM(NP)) i_slc_lane_regs (
      .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .ctrl_words_per_frame(cfw_in),
      .link_cfg_octets(octets), .logical_lane_data(ldata),
      .serial_out_lane_zero(so0), .serial_out_lane_one(so1),
      .serial_out_lane_two(so2), .serial_out_lane_three(so3),
      .lane_powered_down(lane_pd));

   slc_rx_model #(.W(W)) i_slc_rx_model (
      .hclk(hclk), .hresetn(hresetn), .lane0(so0), .lane1(so1),
      .lane2(so2), .lane3(so3), .lane_off(lane_pd),
      .rx_words_r(rx_words), .rx_off_r(rx_off));

   // Closing verdict, shared by the main sequence and the watchdog
   task automatic give_verdict();
      if (errors == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : give_verdict

   // Word compare with !==; an unknown bit matches only an unknown bit
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Single AHB write; request held until hready is seen high
   task automatic ahb_wr(input logic [11:0] idx, input logic [7:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {18'h0, idx, 2'b00};
      htrans <= 2'b10;
      hwrite <= 1'b1;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {24'h0, d};
      do @(posedge hclk); while (hreadyout !== 1'b1);
   endtask : ahb_wr

   // Single AHB read; data and response taken at the closing edge
   task automatic ahb_rd(input logic [11:0] idx, input logic [31:0] exp);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {18'h0, idx, 2'b00};
      htrans <= 2'b10;
      hwrite <= 1'b0;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      chk({hrdata[31:1], hresp}, {exp[31:1], 1'b0});
      chk(hrdata, exp);
   endtask : ahb_rd

   // Expected checksum: octet sum plus the lane's assignment code, mod 256
   function automatic logic [7:0] ck(input int n);
      logic [7:0] s;
      s = {5'h0, map_e[n]};
      for (int i = 0; i < NP; i++) begin
         s = s + octets[i];
      end
      return s;
   endfunction : ck

   // Expected physical lane words for a given set of logical words
   function automatic logic [3:0][W-1:0] lanes_exp(
      input logic [3:0][W-1:0] src);
      logic [3:0][W-1:0] e;
      for (int n = 0; n < 4; n++) begin
         e[n] = src[map_e[n][1:0]] ^ {W{inv_e[2*n]}};
         // Power-down and reserved codes both silence the lane
         if (pd_e[2*n] || map_e[n] > 3'h3) begin
            e[n] = '0;
         end
      end
      return e;
   endfunction : lanes_exp

   // Lane words as seen by the receiver, after the pipeline settles
   task automatic check_lanes();
      repeat (3) @(posedge hclk);
      chk(rx_words, lanes_exp(ldata));
      chk({28'h0, rx_off},
          {28'h0, pd_e[6], pd_e[4], pd_e[2], pd_e[0]});
   endtask : check_lanes

   // Defaults after reset and the five-bit read-only count
   task automatic t_defaults();
      for (int n = 0; n < 4; n++) begin
         ahb_rd(MAPI[n], n);
         ahb_rd(SLC_IDX_CK0 + 12'(n), {24'h0, 8'hC3 + 8'(n)});
      end
      ahb_rd(SLC_IDX_PD, 32'h0);
      ahb_rd(SLC_IDX_INV, 32'h0);
      ahb_rd(SLC_IDX_CFW, 32'h1F);
      check_lanes();
   endtask : t_defaults

   // Writes to read-only and unmapped places are dropped
   task automatic t_read_only();
      ahb_wr(SLC_IDX_CFW, 8'hFF);
      ahb_rd(SLC_IDX_CFW, 32'h1F);
      ahb_wr(SLC_IDX_CK1, 8'h00);
      ahb_rd(SLC_IDX_CK1, {24'h0, ck(1)});
      ahb_wr(12'h5B1, 8'hFF);
      ahb_rd(12'h5B1, 32'h0);
   endtask : t_read_only

   // All lanes off, then one lane alone; odd bits never stick
   task automatic t_powerdown();
      ahb_wr(SLC_IDX_PD, 8'hFF);
      pd_e = 8'h55;
      ahb_rd(SLC_IDX_PD, 32'h55);
      check_lanes();
      ahb_wr(SLC_IDX_PD, 8'h04);
      pd_e = 8'h04;
      ahb_rd(SLC_IDX_PD, 32'h04);
      check_lanes();
      ahb_wr(SLC_IDX_PD, 8'h00);
      pd_e = 8'h00;
   endtask : t_powerdown

   // Reversed mapping; checksums follow codes and wrap modulo 256
   task automatic t_mapping();
      for (int n = 0; n < 4; n++) begin
         map_e[n] = 3'(3 - n);
         ahb_wr(MAPI[n], {5'h1F, map_e[n]});
         ahb_rd(MAPI[n], {29'h0, map_e[n]});
      end
      check_lanes();
      @(posedge hclk);
      octets[1] <= 8'h50;
      @(posedge hclk);
      for (int n = 0; n < 4; n++) begin
         ahb_rd(SLC_IDX_CK0 + 12'(n), {24'h0, ck(n)});
      end
      // A reserved code silences the lane rather than alias a real one
      map_e[0] = 3'h5;
      ahb_wr(SLC_IDX_MAP0, 8'h05);
      ahb_rd(SLC_IDX_MAP0, 32'h5);
      check_lanes();
      ahb_rd(SLC_IDX_CK0, {24'h0, ck(0)});
   endtask : t_mapping

   // Inversion on even bits only; odd bits are stored but inert
   task automatic t_invert();
      ahb_wr(SLC_IDX_INV, 8'h05);
      inv_e = 8'h05;
      ahb_rd(SLC_IDX_INV, 32'h05);
      check_lanes();
      ahb_wr(SLC_IDX_INV, 8'hAA);
      inv_e = 8'hAA;
      ahb_rd(SLC_IDX_INV, 32'hAA);
      check_lanes();
   endtask : t_invert

   // Clock enable low freezes lanes while inputs move; checksums are read only after enable returns
   task automatic t_freeze();
      logic [3:0][W-1:0] old;
      old = ldata;
      @(posedge hclk);
      clk_en <= 1'b0;
      ldata <= ~old;
      octets[2] <= 8'h21;
      repeat (4) @(posedge hclk);
      chk(rx_words, lanes_exp(old));
      clk_en <= 1'b1;
      ldata <= old;
      check_lanes();
      ahb_rd(SLC_IDX_CK1, {24'h0, ck(1)});
   endtask : t_freeze

   // A reset in mid-run brings every field back to its default
   task automatic t_reset();
      @(posedge hclk);
      hresetn <= 1'b0;
      octets <= {{(NP-1){8'h00}}, 8'hC3};
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      map_e = '{3'h0, 3'h1, 3'h2, 3'h3};
      pd_e = 8'h00;
      inv_e = 8'h00;
      t_defaults();
   endtask : t_reset

   // Main sequence: 20 cycles of reset, then each scenario
   initial begin
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      t_defaults();
      t_read_only();
      t_powerdown();
      t_mapping();
      t_invert();
      t_freeze();
      t_reset();
      give_verdict();
   end

   // Watchdog: the whole run needs well under a few thousand cycles
   initial begin
      repeat (20000) @(posedge hclk);
      errors++;
      give_verdict();
   end
endmodule : tb_slc_lane_regs
